// ==== tcr_defs.vh ====
// constants for the capture / reload / baud timer
`ifndef TCR_DEFS_VH
`define TCR_DEFS_VH

// ****************************************
// register indices, byte address = 4 * index
// ****************************************
`define TCR_IDX_CTRL      8'hC8
`define TCR_IDX_CLK       8'hC9
`define TCR_IDX_RCAP_LO   8'hCA
`define TCR_IDX_RCAP_HI   8'hCB
`define TCR_IDX_CNT_LO    8'hCC
`define TCR_IDX_CNT_HI    8'hCD

// ****************************************
// timer_ctrl_reg bit positions
// ****************************************
`define TCR_B_OVF         7
`define TCR_B_EXT         6
`define TCR_B_RXB         5
`define TCR_B_TXB         4
`define TCR_B_EXEN        3
`define TCR_B_RUN         2
`define TCR_B_SRC         1
`define TCR_B_CPRL        0

// clock_ctrl_reg bit position of prescale_sel
`define TCR_B_PRESC       0

// ****************************************
// reset values and counting constants
// ****************************************
`define TCR_RST_BYTE      8'h00
`define TCR_RST_WORD      16'h0000
`define TCR_CNT_MAX       16'hFFFF
`define TCR_DIV12_LAST    4'hB
`define TCR_DIV_ZERO      4'h0
`define TCR_DIV_ONE       4'h1

`endif

// ==== tcr_timer.v ====
// 16-bit capture / auto-reload / baud timer with an apb register port
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tcr_defs.vh"

module tcr_timer (
    // apb slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output reg         pslverr,
    // external pins
    input  wire        ext_count_pin,
    input  wire        ext_trigger_pin,
    // interrupt gating from the core's enable register
    input  wire        irq_enable,
    // event outputs
    output reg         timer_irq,
    output reg         rx_baud_tick,
    output reg         tx_baud_tick,
    output reg         adc_start_trig
);

    // ****************************************
    // software state
    // ****************************************
    reg  [7:0]  ctrl_r;
    reg  [7:0]  ctrl_nxt;
    reg         presc_r;
    reg  [15:0] count_r;
    reg  [15:0] count_nxt;
    reg  [15:0] rcap_r;
    reg  [15:0] rcap_nxt;
    reg  [3:0]  div_r;
    reg  [3:0]  div_nxt;
    reg         half_r;

    // ****************************************
    // pin synchronisers
    // ****************************************
    reg  [1:0]  cnt_sync_r;
    reg  [1:0]  trg_sync_r;
    reg         cnt_prev_r;
    reg         trg_prev_r;

    // ****************************************
    // apb decode
    // ****************************************
    wire        setup_ph;
    wire        wr_en;
    wire        word_ok;
    wire [7:0]  idx;
    wire        hit_ctrl;
    wire        hit_clk;
    wire        hit_rcl;
    wire        hit_rch;
    wire        hit_cnl;
    wire        hit_cnh;
    wire        hit_any;

    assign idx      = paddr[9:2];
    assign word_ok  = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    assign hit_ctrl = word_ok && (idx == `TCR_IDX_CTRL);
    assign hit_clk  = word_ok && (idx == `TCR_IDX_CLK);
    assign hit_rcl  = word_ok && (idx == `TCR_IDX_RCAP_LO);
    assign hit_rch  = word_ok && (idx == `TCR_IDX_RCAP_HI);
    assign hit_cnl  = word_ok && (idx == `TCR_IDX_CNT_LO);
    assign hit_cnh  = word_ok && (idx == `TCR_IDX_CNT_HI);
    assign hit_any  = hit_ctrl | hit_clk | hit_rcl | hit_rch | hit_cnl | hit_cnh;

    // zero wait states: read data is staged during the setup cycle
    assign pready   = 1'b1;
    assign setup_ph = psel & ~penable;
    // an unmapped write is refused and changes nothing
    assign wr_en    = psel & penable & pwrite & hit_any;

    // ****************************************
    // mode decode
    // ****************************************
    wire run;
    wire baud;
    wire capture;
    wire reload;
    wire ext_en;
    wire src_ext;

    assign run     = ctrl_r[`TCR_B_RUN];
    assign baud    = ctrl_r[`TCR_B_RXB] | ctrl_r[`TCR_B_TXB];
    // baud selects take priority over the capture select
    assign capture = run & ~baud & ctrl_r[`TCR_B_CPRL];
    assign reload  = run & ~baud & ~ctrl_r[`TCR_B_CPRL];
    assign ext_en  = ctrl_r[`TCR_B_EXEN];
    assign src_ext = ctrl_r[`TCR_B_SRC];

    // ****************************************
    // edge detection and count enable
    // ****************************************
    wire cnt_fall;
    wire trg_fall;
    wire int_tick;
    wire inc;
    wire roll;
    wire trig;

    // only the second flop and the held copy feed logic
    assign cnt_fall = cnt_prev_r & ~cnt_sync_r[1];
    assign trg_fall = trg_prev_r & ~trg_sync_r[1];

    // internal tick: half rate in baud mode, else one or twelve
    assign int_tick = baud ? half_r :
                      (presc_r ? 1'b1 : (div_r == `TCR_DIV12_LAST));
    assign inc      = run & (src_ext ? cnt_fall : int_tick);
    assign roll     = inc & (count_r == `TCR_CNT_MAX);
    // trigger pin is dead while disabled or stopped
    assign trig     = run & ext_en & trg_fall;

    // ****************************************
    // synchronisers and prescaler
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_sync_r <= 2'h0;
            trg_sync_r <= 2'h0;
            cnt_prev_r <= 1'b0;
            trg_prev_r <= 1'b0;
            div_r      <= `TCR_DIV_ZERO;
            half_r     <= 1'b0;
        end else begin
            cnt_sync_r <= {cnt_sync_r[0], ext_count_pin};
            trg_sync_r <= {trg_sync_r[0], ext_trigger_pin};
            cnt_prev_r <= cnt_sync_r[1];
            trg_prev_r <= trg_sync_r[1];
            div_r      <= div_nxt;
            // the half-rate toggle only runs while the timer does
            half_r     <= run & ~half_r;
        end
    end

    // divide-by-twelve counter, held in reset while stopped
    always @* begin
        div_nxt = div_r;
        if (!run || div_r == `TCR_DIV12_LAST) begin
            div_nxt = `TCR_DIV_ZERO;
        end else begin
            div_nxt = div_r + `TCR_DIV_ONE;
        end
    end

    // ****************************************
    // counter, capture/reload register, flags
    // ****************************************
    always @* begin
        count_nxt = count_r;
        rcap_nxt  = rcap_r;
        ctrl_nxt  = ctrl_r;

        // counting and rollover
        if (inc) begin
            count_nxt = count_r + 16'h0001;
        end
        if (roll && (reload || baud)) begin
            count_nxt = rcap_r;
        end
        // a reload trigger restarts from the reload value
        if (trig && reload) begin
            count_nxt = rcap_r;
        end

        // software write to the counter bytes wins over counting
        if (wr_en && hit_cnl) begin
            count_nxt[7:0] = pwdata[7:0];
        end
        if (wr_en && hit_cnh) begin
            count_nxt[15:8] = pwdata[7:0];
        end

        // software writes to the reload pair
        if (wr_en && hit_rcl) begin
            rcap_nxt[7:0] = pwdata[7:0];
        end
        if (wr_en && hit_rch) begin
            rcap_nxt[15:8] = pwdata[7:0];
        end
        // a capture in the same cycle beats the software write
        if (trig && capture) begin
            rcap_nxt = count_r;
        end

        // control byte: software may set or clear any bit
        if (wr_en && hit_ctrl) begin
            ctrl_nxt = pwdata[7:0];
        end
        // hardware sets win over a software clear in the same cycle
        if (roll && !baud) begin
            ctrl_nxt[`TCR_B_OVF] = 1'b1;
        end
        if (trig) begin
            ctrl_nxt[`TCR_B_EXT] = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r  <= `TCR_RST_BYTE;
            presc_r <= 1'b0;
            count_r <= `TCR_RST_WORD;
            rcap_r  <= `TCR_RST_WORD;
        end else begin
            ctrl_r  <= ctrl_nxt;
            count_r <= count_nxt;
            rcap_r  <= rcap_nxt;
            if (wr_en && hit_clk) begin
                presc_r <= pwdata[`TCR_B_PRESC];
            end
        end
    end

    // ****************************************
    // event outputs
    // ****************************************
    // ticks and triggers are one-cycle pulses, one clock after the event
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_baud_tick   <= 1'b0;
            tx_baud_tick   <= 1'b0;
            adc_start_trig <= 1'b0;
            timer_irq      <= 1'b0;
        end else begin
            rx_baud_tick   <= roll & ctrl_r[`TCR_B_RXB];
            tx_baud_tick   <= roll & ctrl_r[`TCR_B_TXB];
            // the converter sees every rollover, also in baud mode
            adc_start_trig <= roll;
            // level request follows the flags; the core gates it
            timer_irq      <= irq_enable &
                              (ctrl_nxt[`TCR_B_OVF] | ctrl_nxt[`TCR_B_EXT]);
        end
    end

    // ****************************************
    // apb read path
    // ****************************************
    // staged at the setup edge so prdata leaves a flop;
    // an unmapped address reads zero with an error
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            pslverr <= ~hit_any;
            prdata  <= 32'h0000_0000;
            if (hit_ctrl) begin
                prdata[7:0] <= ctrl_r;
            end
            if (hit_clk) begin
                prdata[`TCR_B_PRESC] <= presc_r;
            end
            if (hit_rcl) begin
                prdata[7:0] <= rcap_r[7:0];
            end
            if (hit_rch) begin
                prdata[7:0] <= rcap_r[15:8];
            end
            if (hit_cnl) begin
                prdata[7:0] <= count_r[7:0];
            end
            if (hit_cnh) begin
                prdata[7:0] <= count_r[15:8];
            end
        end else if (!psel) begin
            pslverr <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ==== tcr_timer_checker.sv ====
// port assertions for the capture / reload / baud timer
`timescale 1ns/1ps
`default_nettype none
module tcr_timer_checker (
    // apb side
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // events
    input wire logic        irq_enable,
    input wire logic        timer_irq,
    input wire logic        rx_baud_tick,
    input wire logic        tx_baud_tick,
    input wire logic        adc_start_trig
);
    // ****************************************
    // properties on pclk, off during reset
    // ****************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready; pready; endproperty
    property p_err; $rose(pslverr) |-> psel && penable && prdata == 32'h0000_0000; endproperty
    property p_width; psel && penable |-> prdata[31:8] == 24'h00_0000; endproperty
    // request is registered from the next flags, so it changes with them and the gate is the past enable
    property p_gate; timer_irq |-> $past(irq_enable); endproperty
    property p_hold; (timer_irq && irq_enable && !psel) [*2] |=> timer_irq; endproperty
    property p_rx; rx_baud_tick |-> adc_start_trig; endproperty
    property p_rxgap; rx_baud_tick |=> !rx_baud_tick; endproperty
    property p_tx; tx_baud_tick |-> adc_start_trig ##1 !tx_baud_tick; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    a_err: assert property (p_err) else $error("bad error reply");
    a_width: assert property (p_width) else $error("upper read bits set");
    a_gate: assert property (p_gate) else $error("request while disabled");
    a_hold: assert property (p_hold) else $error("flag dropped alone");
    a_rx: assert property (p_rx) else $error("rx tick without rollover");
    a_rxgap: assert property (p_rxgap) else $error("rx tick too long");
    a_tx: assert property (p_tx) else $error("tx tick wrong");
    c_both: cover property (rx_baud_tick && tx_baud_tick);
    c_irq: cover property ($rose(timer_irq));
    c_err: cover property (pslverr);
endmodule
`default_nettype wire

// ==== tcr_pin_model.sv ====
// far side: count and trigger pins, idle high, falling-edge pulses on request
`timescale 1ns/1ps
`default_nettype none
module tcr_pin_model (
    // pulse requests
    input wire logic pclk,
    input wire logic cnt_go,
    input wire logic trg_go,
    // pins
    output logic     ext_count_pin,
    output logic     ext_trigger_pin
);
    logic [1:0] cnt_low_r = 2'h0;
    logic [1:0] trg_low_r = 2'h0;
    // three low clocks so the two-flop sampler is sure to see the level
    always @(posedge pclk) begin
        if (cnt_go)
            cnt_low_r <= 2'h3;
        else if (cnt_low_r != 2'h0)
            cnt_low_r <= cnt_low_r - 2'h1;
        if (trg_go)
            trg_low_r <= 2'h3;
        else if (trg_low_r != 2'h0)
            trg_low_r <= trg_low_r - 2'h1;
    end
    assign ext_count_pin   = (cnt_low_r == 2'h0);
    assign ext_trigger_pin = (trg_low_r == 2'h0);
endmodule
`default_nettype wire

// ==== tb_timer2_capture_reload_baud.sv ====
// self-checking bench for the capture / reload / baud timer
`timescale 1ns/1ps
`default_nettype none
`include "tcr_defs.vh"
module tb_timer2_capture_reload_baud;
    // ****************************************
    // mode table, signals and bus tasks
    // ****************************************
    typedef struct packed {logic [7:0] ctl, ck; logic [15:0] per;
        logic [7:0] rx, tx, rb;} tcr_row_t;
    localparam tcr_row_t rows_tbl [5] = '{
        '{8'h04, 8'h01, 16'h0010, 8'h00, 8'h00, 8'h84},
        '{8'h04, 8'h00, 16'h00C0, 8'h00, 8'h00, 8'h84},
        '{8'h24, 8'h01, 16'h0020, 8'h01, 8'h00, 8'h24},
        '{8'h14, 8'h00, 16'h0020, 8'h00, 8'h01, 8'h14},
        '{8'h35, 8'h01, 16'h0020, 8'h01, 8'h01, 8'h35}};
    localparam logic [11:0] a_ctl = {2'b00, `TCR_IDX_CTRL, 2'b00};
    localparam logic [11:0] a_clk = {2'b00, `TCR_IDX_CLK, 2'b00};
    localparam logic [11:0] a_rlo = {2'b00, `TCR_IDX_RCAP_LO, 2'b00};
    localparam logic [11:0] a_clo = {2'b00, `TCR_IDX_CNT_LO, 2'b00};
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        irq_enable = 1'b0, cnt_go = 1'b0, trg_go = 1'b0, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, rd;
    wire  [31:0] prdata;
    wire         pready, pslverr, ext_count_pin, ext_trigger_pin;
    wire         timer_irq, rx_baud_tick, tx_baud_tick, adc_start_trig;
    int          failures = 0, check_count = 0, n_rx = 0, n_tx = 0, r0, t0, n;
    tcr_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_count_pin(ext_count_pin), .ext_trigger_pin(ext_trigger_pin),
        .irq_enable(irq_enable), .timer_irq(timer_irq), .rx_baud_tick(rx_baud_tick),
        .tx_baud_tick(tx_baud_tick), .adc_start_trig(adc_start_trig));
    tcr_pin_model pins (.pclk(pclk), .cnt_go(cnt_go), .trg_go(trg_go),
        .ext_count_pin(ext_count_pin), .ext_trigger_pin(ext_trigger_pin));
    // 25 MHz clock
    initial forever #20 pclk = ~pclk;
    // every edge goes through here so no tick is missed
    task cyc;
        @(posedge pclk);
        n_rx += (rx_baud_tick === 1'b1);
        n_tx += (tx_baud_tick === 1'b1);
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one transfer, then an idle edge so a next call never restrobes in one step
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        cyc;
        penable <= 1'b1;
        cyc;
        // no wait count is assumed; only the watchdog ends a stuck access
        while (pready !== 1'b1)
            cyc;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        cyc;
    endtask
    task rdc(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(rd, {24'h00_0000, e});
    endtask
    task setw(input logic [11:0] a, input logic [15:0] v);
        apb(1'b1, a, v[7:0]);
        apb(1'b1, a + 12'h004, v[15:8]);
    endtask
    // one falling edge on the trigger pin (t) or the count pin
    task pin(input logic t);
        trg_go <= t;
        cnt_go <= ~t;
        cyc;
        trg_go <= 1'b0;
        cnt_go <= 1'b0;
        repeat (6) cyc;
    endtask
    // n = edges until the next rollover pulse
    task roll;
        cyc;
        n = 1;
        while (adc_start_trig !== 1'b1) begin
            cyc;
            n++;
        end
    endtask
    task print_verdict;
        if (failures == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // watchdog, well past the thousand or so edges the run needs
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        print_verdict;
    end
    // main sequence
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        irq_enable <= 1'b1;
        cyc;
        for (int i = 0; i < 6; i++)
            rdc(a_ctl + 12'(4 * i), 8'h00);
        apb(1'b1, 12'h338, 8'h77);
        chk(er, 1'b1);
        rdc(12'h338, 8'h00);
        foreach (rows_tbl[i]) begin
            apb(1'b1, a_ctl, 8'h00);
            apb(1'b1, a_clk, rows_tbl[i].ck);
            setw(a_rlo, 16'hFFF0);
            setw(a_clo, 16'hFFF0);
            apb(1'b1, a_ctl, rows_tbl[i].ctl);
            roll;
            r0 = n_rx;
            t0 = n_tx;
            roll;
            chk(n, rows_tbl[i].per);
            chk(n_rx - r0, rows_tbl[i].rx);
            chk(n_tx - t0, rows_tbl[i].tx);
            rdc(a_ctl, rows_tbl[i].rb);
        end
        setw(a_rlo, 16'hFFFC);
        setw(a_clo, 16'hFFFC);
        apb(1'b1, a_ctl, 8'h26);
        r0 = n_rx;
        repeat (8) pin(1'b0);
        chk(n_rx - r0, 2);
        setw(a_rlo, 16'h00AA);
        setw(a_clo, 16'h1234);
        apb(1'b1, a_ctl, 8'h07);
        pin(1'b1);
        rdc(a_ctl, 8'h07);
        rdc(a_rlo, 8'hAA);
        apb(1'b1, a_ctl, 8'h0F);
        pin(1'b1);
        rdc(a_ctl, 8'h4F);
        rdc(a_rlo + 12'h004, 8'h12);
        chk(timer_irq, 1'b1);
        setw(a_clo, 16'hFFFF);
        pin(1'b0);
        rdc(a_ctl, 8'hCF);
        rdc(a_clo, 8'h00);
        apb(1'b1, a_ctl, 8'h0E);
        repeat (2) cyc;
        chk(timer_irq, 1'b0);
        setw(a_rlo, 16'hAB00);
        pin(1'b1);
        rdc(a_clo + 12'h004, 8'hAB);
        chk(timer_irq, 1'b1);
        apb(1'b1, a_ctl, 8'h2E);
        pin(1'b1);
        rdc(a_ctl, 8'h6E);
        // the core's gate alone drops and restores the request
        irq_enable <= 1'b0;
        repeat (2) cyc;
        chk(timer_irq, 1'b0);
        irq_enable <= 1'b1;
        repeat (2) cyc;
        chk(timer_irq, 1'b1);
        // a reset in mid-run clears every register and the request
        presetn <= 1'b0;
        repeat (2) cyc;
        presetn <= 1'b1;
        cyc;
        chk(timer_irq, 1'b0);
        for (int i = 0; i < 6; i++)
            rdc(a_ctl + 12'(4 * i), 8'h00);
        print_verdict;
    end
endmodule
bind tcr_timer tcr_timer_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_enable(irq_enable), .timer_irq(timer_irq), .rx_baud_tick(rx_baud_tick),
    .tx_baud_tick(tx_baud_tick), .adc_start_trig(adc_start_trig));
`default_nettype wire
